// ===== logic/xbin.v
`timescale 1ns/1ps
`include "xbin_regs.vh"

// ==========================================
// one select field, loaded by its own decoded strobe
module xbin_sel_reg #(
  parameter W = 2,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input wire ref_clk,
  input wire resetn,
  input wire load,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q <= RST;
    end else if (load) begin
      q <= d;
    end
  end

endmodule

module xbin (
  input wire ref_clk,
  input wire resetn,
  input wire ce,
  input wire [31:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  input wire [5:0] pa_in,
  input wire [7:0] pb_in,
  input wire [4:0] pc_in,
  input wire [2:0] capture2_pin,
  output reg timer1_count_input,
  output reg timer2_count_input,
  output reg capture0_input,
  output reg capture1_input,
  output reg capture2_input,
  output reg capture3_input,
  output reg external_clock_input
);

  // ==========================================
  // select registers
  wire [1:0] timer1_count_input_select;
  wire [1:0] timer2_count_input_select;
  wire [1:0] capture0_input_select;
  wire [1:0] capture1_input_select;
  wire [1:0] capture2_input_select;
  wire [1:0] capture3_input_select;
  wire [2:0] external_clock_input_select;

  wire wr_en;
  wire rd_en;

  assign wr_en = wr & ce;
  assign rd_en = rd & ce;

  // ==========================================
  // address decode, one hit per select register
  wire hit_tim1;
  wire hit_tim2;
  wire hit_cap0;
  wire hit_cap1;
  wire hit_cap2;
  wire hit_cap3;
  wire hit_eclk;

  assign hit_tim1 = (addr == `XBIN_TIM1_ADDR);
  assign hit_tim2 = (addr == `XBIN_TIM2_ADDR);
  assign hit_cap0 = (addr == `XBIN_CAP0_ADDR);
  assign hit_cap1 = (addr == `XBIN_CAP1_ADDR);
  assign hit_cap2 = (addr == `XBIN_CAP2_ADDR);
  assign hit_cap3 = (addr == `XBIN_CAP3_ADDR);
  assign hit_eclk = (addr == `XBIN_ECLK_ADDR);

  // every field starts at code zero, so all routed inputs sit low
  // one field module per register keeps load and reset paths identical
  xbin_sel_reg #(.W(`XBIN_SEL2_W), .RST(`XBIN_SEL2_RST)) u_tim1 (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .load(wr_en & hit_tim1),
    .d(wdata[`XBIN_SEL2_W-1:0]),
    .q(timer1_count_input_select)
  );

  xbin_sel_reg #(.W(`XBIN_SEL2_W), .RST(`XBIN_SEL2_RST)) u_tim2 (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .load(wr_en & hit_tim2),
    .d(wdata[`XBIN_SEL2_W-1:0]),
    .q(timer2_count_input_select)
  );

  xbin_sel_reg #(.W(`XBIN_SEL2_W), .RST(`XBIN_SEL2_RST)) u_cap0 (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .load(wr_en & hit_cap0),
    .d(wdata[`XBIN_SEL2_W-1:0]),
    .q(capture0_input_select)
  );

  xbin_sel_reg #(.W(`XBIN_SEL2_W), .RST(`XBIN_SEL2_RST)) u_cap1 (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .load(wr_en & hit_cap1),
    .d(wdata[`XBIN_SEL2_W-1:0]),
    .q(capture1_input_select)
  );

  xbin_sel_reg #(.W(`XBIN_SEL2_W), .RST(`XBIN_SEL2_RST)) u_cap2 (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .load(wr_en & hit_cap2),
    .d(wdata[`XBIN_SEL2_W-1:0]),
    .q(capture2_input_select)
  );

  xbin_sel_reg #(.W(`XBIN_SEL2_W), .RST(`XBIN_SEL2_RST)) u_cap3 (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .load(wr_en & hit_cap3),
    .d(wdata[`XBIN_SEL2_W-1:0]),
    .q(capture3_input_select)
  );

  xbin_sel_reg #(.W(`XBIN_SEL3_W), .RST(`XBIN_SEL3_RST)) u_eclk (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .load(wr_en & hit_eclk),
    .d(wdata[`XBIN_SEL3_W-1:0]),
    .q(external_clock_input_select)
  );

  // ==========================================
  // read port, data valid in the cycle after the strobe, then cleared on the next enabled cycle; held while ce is low
  reg [31:0] next_rdata;

  always @* begin
    next_rdata = 32'h0;
    case (addr)
      `XBIN_TIM1_ADDR: begin
        next_rdata = {30'h0, timer1_count_input_select};
      end
      `XBIN_TIM2_ADDR: begin
        next_rdata = {30'h0, timer2_count_input_select};
      end
      `XBIN_CAP0_ADDR: begin
        next_rdata = {30'h0, capture0_input_select};
      end
      `XBIN_CAP1_ADDR: begin
        next_rdata = {30'h0, capture1_input_select};
      end
      `XBIN_CAP2_ADDR: begin
        next_rdata = {30'h0, capture2_input_select};
      end
      `XBIN_CAP3_ADDR: begin
        next_rdata = {30'h0, capture3_input_select};
      end
      `XBIN_ECLK_ADDR: begin
        next_rdata = {29'h0, external_clock_input_select};
      end
      default: begin
        next_rdata = 32'h0;
      end
    endcase
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 32'h0;
    end else if (ce) begin
      if (rd_en) begin
        rdata <= next_rdata;
      end else begin
        rdata <= 32'h0;
      end
    end
  end

  // ==========================================
  // routing
  // the muxes stay combinational: a flop here would add a cycle of
  // latency to count and clock edges and could not pass a fast clock
  always @* begin
    case (timer1_count_input_select)
      `XBIN_C2_ONE: begin
        timer1_count_input = pa_in[4];
      end
      `XBIN_C2_TWO: begin
        timer1_count_input = pb_in[4];
      end
      `XBIN_C2_THREE: begin
        timer1_count_input = pc_in[4];
      end
      default: begin
        timer1_count_input = 1'b0;
      end
    endcase
  end

  // the port logic may still drive pb3; software keeps it quiet
  always @* begin
    case (timer2_count_input_select)
      `XBIN_C2_TWO: begin
        timer2_count_input = pb_in[3];
      end
      default: begin
        timer2_count_input = 1'b0;
      end
    endcase
  end

  // routed capture pins are not isolated from port logic
  always @* begin
    case (capture0_input_select)
      `XBIN_C2_ONE: begin
        capture0_input = pa_in[5];
      end
      `XBIN_C2_TWO: begin
        capture0_input = pb_in[2];
      end
      default: begin
        capture0_input = 1'b0;
      end
    endcase
  end

  always @* begin
    case (capture1_input_select)
      `XBIN_C2_ONE: begin
        capture1_input = pa_in[0];
      end
      `XBIN_C2_TWO: begin
        capture1_input = pb_in[0];
      end
      default: begin
        capture1_input = 1'b0;
      end
    endcase
  end

  // capture2 candidates arrive as a small pin group chosen at top level
  always @* begin
    case (capture2_input_select)
      `XBIN_C2_ONE: begin
        capture2_input = capture2_pin[0];
      end
      `XBIN_C2_TWO: begin
        capture2_input = capture2_pin[1];
      end
      `XBIN_C2_THREE: begin
        capture2_input = capture2_pin[2];
      end
      default: begin
        capture2_input = 1'b0;
      end
    endcase
  end

  always @* begin
    case (capture3_input_select)
      `XBIN_C2_ONE: begin
        capture3_input = pc_in[0];
      end
      default: begin
        capture3_input = 1'b0;
      end
    endcase
  end

  // glitches here reach the clock block directly; change it only while
  // the clock block is not using the pin source
  always @* begin
    case (external_clock_input_select)
      `XBIN_C3_ONE: begin
        external_clock_input = pa_in[3];
      end
      `XBIN_C3_TWO: begin
        external_clock_input = pc_in[1];
      end
      default: begin
        external_clock_input = 1'b0;
      end
    endcase
  end

endmodule

// ===== logic/xbin_regs.vh
`ifndef XBIN_REGS_VH
`define XBIN_REGS_VH

// ==========================================
// register byte addresses
`define XBIN_TIM1_ADDR 32'h4050003c
`define XBIN_TIM2_ADDR 32'h40500040
`define XBIN_CAP0_ADDR 32'h40500044
`define XBIN_CAP1_ADDR 32'h40500048
`define XBIN_CAP2_ADDR 32'h4050004c
`define XBIN_CAP3_ADDR 32'h40500050
`define XBIN_ECLK_ADDR 32'h40500054

// ==========================================
// field widths and reset values
`define XBIN_SEL2_W 2
`define XBIN_SEL3_W 3
`define XBIN_SEL2_RST 2'h0
`define XBIN_SEL3_RST 3'h0

// ==========================================
// select codes
`define XBIN_C2_ZERO 2'h0
`define XBIN_C2_ONE 2'h1
`define XBIN_C2_TWO 2'h2
`define XBIN_C2_THREE 2'h3
`define XBIN_C3_ZERO 3'h0
`define XBIN_C3_ONE 3'h1
`define XBIN_C3_TWO 3'h2

`endif

// ===== sim/xbin_asserts.sv
`timescale 1ns/1ps
`include "xbin_regs.vh"
// ==========================================
// port checker
module xbin_chk (
  input wire ref_clk,
  input wire resetn,
  input wire ce,
  input wire [31:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata,
  input wire [5:0] pa_in,
  input wire [7:0] pb_in,
  input wire [4:0] pc_in,
  input wire [2:0] capture2_pin,
  input wire timer1_count_input,
  input wire timer2_count_input,
  input wire capture0_input,
  input wire capture1_input,
  input wire capture2_input,
  input wire capture3_input,
  input wire external_clock_input
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_t1; timer1_count_input |-> pa_in[4] || pb_in[4] || pc_in[4]; endproperty
  a_t1: assert property (p_t1) else $error("timer1 input high with no source pin");
  property p_t2; timer2_count_input |-> pb_in[3]; endproperty
  a_t2: assert property (p_t2) else $error("timer2 input high without pb3");
  property p_c0; capture0_input |-> pa_in[5] || pb_in[2]; endproperty
  a_c0: assert property (p_c0) else $error("capture0 input from no pin");
  property p_c1; capture1_input |-> pa_in[0] || pb_in[0]; endproperty
  a_c1: assert property (p_c1) else $error("capture1 input from no pin");
  property p_c2; capture2_input |-> |capture2_pin; endproperty
  a_c2: assert property (p_c2) else $error("capture2 input from no pin");
  property p_c3; capture3_input |-> pc_in[0]; endproperty
  a_c3: assert property (p_c3) else $error("capture3 input high without pc0");
  property p_ck; external_clock_input |-> pa_in[3] || pc_in[1]; endproperty
  a_ck: assert property (p_ck) else $error("clock input from no pin");
  property p_wr; ce && wr && addr == `XBIN_TIM1_ADDR && wdata[1:0] == 2'h1 |=> timer1_count_input == pa_in[4];
  endproperty
  a_wr: assert property (p_wr) else $error("timer1 select write not applied");
  property p_rd; rdata != 32'h0 |-> $past(rd) && rdata[31:3] == 29'h0; endproperty
  a_rd: assert property (p_rd) else $error("read data outside its slot");
  cover property (timer1_count_input);
  cover property (external_clock_input);
  cover property (rd ##1 rdata != 32'h0);
  cover property (!ce && wr);
endmodule
bind xbin xbin_chk chk (.*);

// ===== sim/xbin_bench.sv
`timescale 1ns/1ps
`include "xbin_regs.vh"
// ==========================================
// bench
module xbin_bench;
  reg ref_clk = 1'b0;
  reg resetn = 1'b0;
  reg [31:0] addr = 32'h0;
  reg [31:0] wdata = 32'h0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg ce = 1'b1;
  reg [21:0] pat = 22'h0;
  wire [31:0] rdata;
  wire [5:0] pa_in;
  wire [7:0] pb_in;
  wire [4:0] pc_in;
  wire [2:0] c2p;
  wire [6:0] o;
  integer n_errors = 0;
  integer checked = 0;
  integer r, c, p;
  always #5 ref_clk = ~ref_clk;
  xbin_pins pins (.pat(pat), .pa_in(pa_in), .pb_in(pb_in), .pc_in(pc_in), .capture2_pin(c2p));
  xbin dut (.ref_clk(ref_clk), .resetn(resetn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pa_in(pa_in), .pb_in(pb_in), .pc_in(pc_in), .capture2_pin(c2p),
    .timer1_count_input(o[0]), .timer2_count_input(o[1]), .capture0_input(o[2]), .capture1_input(o[3]),
    .capture2_input(o[4]), .capture3_input(o[5]), .external_clock_input(o[6]));
  // pin index in pat for route*8+code; 31 means tied low
  function [4:0] src(input integer k);
    case (k)
      1: src = 4;
      2: src = 10;
      3: src = 18;
      10: src = 9;
      17: src = 5;
      18: src = 8;
      25: src = 0;
      26: src = 6;
      33: src = 19;
      34: src = 20;
      35: src = 21;
      41: src = 14;
      49: src = 3;
      50: src = 15;
      default: src = 31;
    endcase
  endfunction
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wr_reg(input [31:0] a, input [31:0] d);
    begin
      @(posedge ref_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk);
      wr <= 1'b0;
    end
  endtask
  task rd_chk(input [31:0] a, input [31:0] e);
    begin
      @(posedge ref_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1;
      cmp(rdata, e);
    end
  endtask
  task end_sim;
    begin
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    pat <= 22'h3fffff;
    @(posedge ref_clk);
    #1;
    cmp(o, 32'h0);
    // every code of every route, the chosen pin alone low then alone high
    for (r = 0; r < 7; r = r + 1) begin
      for (c = 0; c < (r == 6 ? 8 : 4); c = c + 1) begin
        wr_reg(`XBIN_TIM1_ADDR + 4 * r, c);
        rd_chk(`XBIN_TIM1_ADDR + 4 * r, c);
        for (p = 0; p < 2; p = p + 1) begin
          @(posedge ref_clk);
          pat <= p ? (22'h1 << src(r * 8 + c)) : ~(22'h1 << src(r * 8 + c));
          #1;
          cmp(o[r], p && src(r * 8 + c) != 5'd31);
        end
      end
    end
    // clock enable low: write and read strobes are ignored, timer1 keeps code 3
    @(posedge ref_clk);
    ce <= 1'b0;
    wr_reg(`XBIN_TIM1_ADDR, 32'h1);
    rd_chk(`XBIN_TIM1_ADDR, 32'h0);
    @(posedge ref_clk);
    ce <= 1'b1;
    pat <= 22'h1 << 18;
    #1;
    cmp(o[0], 1'b1);
    rd_chk(`XBIN_TIM1_ADDR, 32'h3);
    wr_reg(`XBIN_TIM1_ADDR, 32'hffffffff);
    rd_chk(`XBIN_TIM1_ADDR, 32'h3);
    wr_reg(32'h40500058, 32'h1);
    rd_chk(32'h40500058, 32'h0);
    // second reset in mid-run must clear every field
    @(posedge ref_clk);
    resetn <= 1'b0;
    @(posedge ref_clk);
    resetn <= 1'b1;
    pat <= 22'h3fffff;
    #1;
    cmp(o, 32'h0);
    rd_chk(`XBIN_ECLK_ADDR, 32'h0);
    end_sim;
  end
endmodule

// ===== sim/xbin_pins.sv
`timescale 1ns/1ps
// ==========================================
// port pin model
module xbin_pins (
  input wire [21:0] pat,
  output wire [5:0] pa_in,
  output wire [7:0] pb_in,
  output wire [4:0] pc_in,
  output wire [2:0] capture2_pin
);
  // port drivers and pull-ups kept off, so only the pattern reaches the pins
  assign {capture2_pin, pc_in, pb_in, pa_in} = pat;
endmodule
